// >>> rtl/dstk_pkg.sv
// package for the dual slope touch key sequencer: register map, fields, tables
// assumes a 32-bit classic wishbone slave, one register per aligned word
`default_nettype none
package dstk_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG_A = 16'ha018;
  localparam logic [15:0] IDX_CFG_B = 16'ha019;
  localparam logic [15:0] IDX_CFG_C = 16'ha01a;
  localparam logic [15:0] IDX_CFG_D = 16'ha01b;
  localparam logic [15:0] IDX_HPC_L = 16'ha01c;
  localparam logic [15:0] IDX_HPC_H = 16'ha01d;
  localparam logic [15:0] IDX_LPC_L = 16'ha01e;
  localparam logic [15:0] IDX_LPC_H = 16'ha01f;
  localparam logic [15:0] IDX_BASE_L = 16'ha028;
  localparam logic [15:0] IDX_BASE_H = 16'ha029;
  localparam logic [15:0] IDX_THR_L = 16'ha02a;
  localparam logic [15:0] IDX_THR_H = 16'ha02b;
  localparam logic [15:0] IDX_DC_BIAS = 16'ha02c;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions of config a
  localparam int A_EN = 7;
  localparam int A_SHIELD = 3;
  localparam int A_IEN = 2;
  localparam int A_LPM = 1;
  localparam int A_AUTO = 0;
  // field positions of config c
  localparam int C_SEED = 2;
  localparam int C_THRSEL = 1;
  localparam int C_AUTOLF = 0;
  // field positions of config d / command
  localparam int D_GAPEN = 4;
  localparam int D_PRND = 3;
  localparam int D_NOISE = 2;
  localparam int D_IRQF = 1;
  localparam int D_START = 0;
  // conversion clock divider: last count of each system clock divide code
  localparam logic [2:0] CS_SLOW = 3'h7;
  localparam logic [4:0] DIV_LAST [0:6] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0f, 5'h1f};
  // sequence length in conversion clocks per cycle code; code 7 reuses the longest
  localparam logic [15:0] CYC_LEN [0:7] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
                                            16'h3000, 16'h4000, 16'h8000, 16'h8000};
  // last sequence index per repeat code: 1, 4, 8, 16 sequences
  localparam logic [3:0] RPT_LAST [0:3] = '{4'h0, 4'h3, 4'h7, 4'hf};
  localparam int SETTLE_UNIT_SH = 2;   // settle unit of 4 clocks
  localparam int GAP_UNIT_SH = 8;      // gap unit of 256 clocks
  localparam int NOISE_UNIT_SH = 3;    // noise unit of 8 clocks
  localparam int AVG_BASE_SH = 5;      // 32-deep average at code 0
  localparam logic [7:0] LFSR_SEED = 8'h5a;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAP = 5'h02,
    ST_SETTLE = 5'h04,
    ST_COUNT = 5'h08,
    ST_DONE = 5'h10
  } dstk_state_type;
  // controls toward the analog front end
  typedef struct packed {
    logic analog_on;        // converter circuits powered
    logic comparator_low_power;
    logic integ_zero;       // hold integration capacitor at its start level
    logic charge_up;        // 1 charge phase, 0 discharge phase
    logic transfer;         // one charge transfer this conversion clock
    logic guard_drive;      // shield pin replica of key electrode
    logic [2:0] reference_cap_select;
    logic [7:0] dc_bias;    // current/resistor enables and bias select
  } dstk_afe_type;
endpackage : dstk_pkg
`default_nettype wire

// >>> rtl/dstk_sequencer.sv
// dual slope touch key sequencer: wishbone register file, conversion clock,
// phase counting, repeat accumulation, moving average baseline, auto wake.
// assumes comparator input synchronous to clk_i; slow oscillator sampled here.
`default_nettype none
module dstk_sequencer (
  input wire logic clk_i,                   // system clock, 50 MHz
  input wire logic rst_i,                   // synchronous reset, active high
  input wire logic cyc_i,                   // wishbone cycle
  input wire logic stb_i,                   // wishbone strobe
  input wire logic we_i,                    // wishbone write
  input wire logic [17:0] adr_i,            // wishbone byte address
  input wire logic [3:0] sel_i,             // wishbone byte select
  input wire logic [31:0] dat_i,            // wishbone write data
  output logic [31:0] dat_o,                // wishbone read data
  output logic ack_o,                       // wishbone acknowledge
  input wire logic slow_osc_i,              // slow oscillator level
  input wire logic comp_i,                  // comparator: 1 above upper threshold band
  output dstk_pkg::dstk_afe_type afe_o,     // front end controls
  output logic irq_o,                       // conversion interrupt, level
  output logic wake_o                       // auto detect wakeup request, level
);
  // register file
  logic [7:0] cfg_a_ff, cfg_b_ff, cfg_c_ff, dc_bias_ff;
  logic [2:0] cap_sel_ff;
  logic gap_en_ff, prnd_en_ff, noise_flag_ff, irq_flag_ff;
  logic [15:0] hpc_ff, lpc_ff, base_ff, thr_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  // sequencer
  dstk_pkg::dstk_state_type state_ff;
  logic [15:0] cnt_ff, acc_h_ff, acc_l_ff;
  logic [3:0] seq_ff;
  logic phase_ff, first_ff, auto_d_ff;
  logic [7:0] run_ff, lfsr_ff;
  logic [4:0] div_ff;
  logic tick_ff, slow_oscillator_s1_ff, slow_oscillator_s2_ff, slow_oscillator_s3_ff, slow_oscillator_half_ff;
  logic irq_o_ff, wake_o_ff;
  dstk_pkg::dstk_afe_type afe_ff;

  // field views
  logic conv_en, auto_mode, busy;
  logic [2:0] clk_sel, cyc_code;
  logic [1:0] repeat_count_field, settle, gap, low_freq_noise_filter, slow;
  logic [15:0] idx;
  logic wr, wr_d, start_req, seq_last, done_evt, auto_hit, noisy, filter_on;
  logic [15:0] settle_len, gap_len, nxt_base, avg_base, thr_eff;
  logic [16:0] avg_diff;
  assign conv_en = cfg_a_ff[dstk_pkg::A_EN];
  assign auto_mode = cfg_a_ff[dstk_pkg::A_AUTO];
  assign clk_sel = cfg_a_ff[6:4];
  assign repeat_count_field = cfg_b_ff[7:6];
  assign settle = cfg_b_ff[5:4];
  assign gap = cfg_b_ff[3:2];
  assign low_freq_noise_filter = cfg_b_ff[1:0];
  assign slow = cfg_c_ff[7:6];
  assign cyc_code = cfg_c_ff[5:3];
  assign busy = (state_ff != dstk_pkg::ST_IDLE);
  assign idx = adr_i[17:2];
  // writes take effect at the edge where the master sees ack
  assign wr = cyc_i & stb_i & we_i & sel_i[0] & ack_ff;
  assign wr_d = wr & (idx == dstk_pkg::IDX_CFG_D);
  assign start_req = wr_d & dat_i[dstk_pkg::D_START] & conv_en & ~auto_mode & ~busy;
  assign settle_len = 16'({settle, 2'b00}) + 16'h0004;
  assign gap_len = {6'h00, gap, 8'h00} + 16'h0100;
  assign seq_last = (seq_ff == dstk_pkg::RPT_LAST[repeat_count_field]);
  assign done_evt = (state_ff == dstk_pkg::ST_DONE);
  assign noisy = (low_freq_noise_filter != 2'b00) && (run_ff >= 8'({low_freq_noise_filter, 3'b000}));
  assign filter_on = (low_freq_noise_filter != 2'b00) && (~auto_mode | cfg_c_ff[dstk_pkg::C_AUTOLF]);
  assign thr_eff = cfg_c_ff[dstk_pkg::C_THRSEL] ? thr_ff + base_ff : thr_ff;
  assign auto_hit = auto_mode & (acc_l_ff > thr_eff);
  // moving average: base += (new - base) / depth, depth 2^(5+slow)
  assign avg_diff = {1'b0, acc_l_ff} - {1'b0, base_ff};
  assign avg_base = base_ff + 16'($signed(avg_diff) >>> (dstk_pkg::AVG_BASE_SH + slow));
  assign nxt_base = (first_ff & cfg_c_ff[dstk_pkg::C_SEED]) ? acc_l_ff : avg_base;

  // wishbone ack and read data; unmapped indices read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= cyc_i & stb_i & ~ack_ff;
      case (idx)
        dstk_pkg::IDX_CFG_A: rdata_ff <= {24'h000000, cfg_a_ff};
        dstk_pkg::IDX_CFG_B: rdata_ff <= {24'h000000, cfg_b_ff};
        dstk_pkg::IDX_CFG_C: rdata_ff <= {24'h000000, cfg_c_ff};
        dstk_pkg::IDX_CFG_D: rdata_ff <= {24'h000000, cap_sel_ff, gap_en_ff, prnd_en_ff,
                                         noise_flag_ff, irq_flag_ff, busy};
        dstk_pkg::IDX_HPC_L: rdata_ff <= {24'h000000, hpc_ff[7:0]};
        dstk_pkg::IDX_HPC_H: rdata_ff <= {24'h000000, hpc_ff[15:8]};
        dstk_pkg::IDX_LPC_L: rdata_ff <= {24'h000000, lpc_ff[7:0]};
        dstk_pkg::IDX_LPC_H: rdata_ff <= {24'h000000, lpc_ff[15:8]};
        dstk_pkg::IDX_BASE_L: rdata_ff <= {24'h000000, base_ff[7:0]};
        dstk_pkg::IDX_BASE_H: rdata_ff <= {24'h000000, base_ff[15:8]};
        dstk_pkg::IDX_THR_L: rdata_ff <= {24'h000000, thr_ff[7:0]};
        dstk_pkg::IDX_THR_H: rdata_ff <= {24'h000000, thr_ff[15:8]};
        dstk_pkg::IDX_DC_BIAS: rdata_ff <= {24'h000000, dc_bias_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_a_ff <= dstk_pkg::REG_RESET;
      cfg_b_ff <= dstk_pkg::REG_RESET;
      cfg_c_ff <= dstk_pkg::REG_RESET;
      dc_bias_ff <= dstk_pkg::REG_RESET;
      cap_sel_ff <= 3'h0;
      gap_en_ff <= 1'b0;
      prnd_en_ff <= 1'b0;
      thr_ff <= 16'h0000;
    end
    else if (wr)
    begin
      case (idx)
        dstk_pkg::IDX_CFG_A: cfg_a_ff <= dat_i[7:0];
        dstk_pkg::IDX_CFG_B: cfg_b_ff <= dat_i[7:0];
        dstk_pkg::IDX_CFG_C: cfg_c_ff <= dat_i[7:0];
        dstk_pkg::IDX_CFG_D:
        begin
          cap_sel_ff <= dat_i[7:5];
          gap_en_ff <= dat_i[dstk_pkg::D_GAPEN];
          prnd_en_ff <= dat_i[dstk_pkg::D_PRND];
        end
        dstk_pkg::IDX_THR_L: thr_ff[7:0] <= dat_i[7:0];
        dstk_pkg::IDX_THR_H: thr_ff[15:8] <= dat_i[7:0];
        dstk_pkg::IDX_DC_BIAS: dc_bias_ff <= dat_i[7:0];
        default: cfg_a_ff <= cfg_a_ff;
      endcase
    end
  end

  // sticky flags: hardware set wins over a software write of zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_flag_ff <= 1'b0;
      noise_flag_ff <= 1'b0;
    end
    else
    begin
      if (done_evt & cfg_a_ff[dstk_pkg::A_IEN] & (~auto_mode | auto_hit))
        irq_flag_ff <= 1'b1;
      else if (wr_d & ~dat_i[dstk_pkg::D_IRQF])
        irq_flag_ff <= 1'b0;
      if (state_ff == dstk_pkg::ST_COUNT && noisy)
        noise_flag_ff <= 1'b1;
      else if (wr_d & ~dat_i[dstk_pkg::D_NOISE])
        noise_flag_ff <= 1'b0;
    end
  end

  // results and baseline; baseline stays software writable between updates
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hpc_ff <= 16'h0000;
      lpc_ff <= 16'h0000;
      base_ff <= 16'h0000;
    end
    else if (done_evt)
    begin
      hpc_ff <= acc_h_ff;
      lpc_ff <= acc_l_ff;
      if (auto_mode)
        base_ff <= nxt_base;
    end
    else if (wr && idx == dstk_pkg::IDX_BASE_L)
      base_ff[7:0] <= dat_i[7:0];
    else if (wr && idx == dstk_pkg::IDX_BASE_H)
      base_ff[15:8] <= dat_i[7:0];
  end

  // slow oscillator synchroniser; second and third stages feed the edge detect
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slow_oscillator_s1_ff <= 1'b0;
      slow_oscillator_s2_ff <= 1'b0;
      slow_oscillator_s3_ff <= 1'b0;
    end
    else
    begin
      slow_oscillator_s1_ff <= slow_osc_i;
      slow_oscillator_s2_ff <= slow_oscillator_s1_ff;
      slow_oscillator_s3_ff <= slow_oscillator_s2_ff;
    end
  end

  // conversion clock as a one-cycle tick; idle while disabled to save power
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !conv_en)
    begin
      div_ff <= 5'h00;
      tick_ff <= 1'b0;
      slow_oscillator_half_ff <= 1'b0;
    end
    else if (clk_sel == dstk_pkg::CS_SLOW)
    begin
      div_ff <= 5'h00;
      if (slow_oscillator_s2_ff & ~slow_oscillator_s3_ff)
        slow_oscillator_half_ff <= ~slow_oscillator_half_ff;
      tick_ff <= slow_oscillator_s2_ff & ~slow_oscillator_s3_ff & slow_oscillator_half_ff;
    end
    else
    begin
      tick_ff <= (div_ff == dstk_pkg::DIV_LAST[clk_sel]);
      div_ff <= (div_ff == dstk_pkg::DIV_LAST[clk_sel]) ? 5'h00 : div_ff + 5'h01;
    end
  end

  // sequencer; gap, settle and count walk on conversion clock ticks only, idle and done move on any clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !conv_en)
    begin
      state_ff <= dstk_pkg::ST_IDLE;
      cnt_ff <= 16'h0000;
      seq_ff <= 4'h0;
      acc_h_ff <= 16'h0000;
      acc_l_ff <= 16'h0000;
      phase_ff <= 1'b1;
      run_ff <= 8'h00;
      first_ff <= 1'b0;
      auto_d_ff <= 1'b0;
      lfsr_ff <= dstk_pkg::LFSR_SEED;
    end
    else
    begin
      auto_d_ff <= auto_mode;
      if (auto_mode & ~auto_d_ff)
        first_ff <= 1'b1;
      else if (done_evt)
        first_ff <= 1'b0;
      if (tick_ff)
        lfsr_ff <= {1'b0, lfsr_ff[7:1]} ^ (lfsr_ff[0] ? dstk_pkg::LFSR_TAPS : 8'h00);
      case (state_ff)
        dstk_pkg::ST_IDLE:
        begin
          cnt_ff <= 16'h0000;
          seq_ff <= 4'h0;
          if (start_req || auto_mode)
          begin
            acc_h_ff <= 16'h0000;
            acc_l_ff <= 16'h0000;
            state_ff <= (auto_mode & gap_en_ff) ? dstk_pkg::ST_GAP : dstk_pkg::ST_SETTLE;
          end
        end
        dstk_pkg::ST_GAP:
          if (tick_ff)
          begin
            cnt_ff <= (cnt_ff == gap_len - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
            if (cnt_ff == gap_len - 16'h0001)
              state_ff <= dstk_pkg::ST_SETTLE;
          end
        dstk_pkg::ST_SETTLE:
        begin
          phase_ff <= 1'b1;
          run_ff <= 8'h00;
          if (tick_ff)
          begin
            cnt_ff <= (cnt_ff == settle_len - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
            if (cnt_ff == settle_len - 16'h0001)
              state_ff <= dstk_pkg::ST_COUNT;
          end
        end
        dstk_pkg::ST_COUNT:
          if (tick_ff)
          begin
            // a stalled transfer still uses up a cycle, so the length stays exact
            if (~prnd_en_ff | lfsr_ff[0])
            begin
              if (phase_ff ? comp_i : ~comp_i)
              begin
                phase_ff <= ~phase_ff;
                run_ff <= 8'h00;
              end
              else if (run_ff != 8'hff)
                run_ff <= run_ff + 8'h01;
            end
            if (!(filter_on && noisy))
            begin
              if (phase_ff)
                acc_h_ff <= acc_h_ff + 16'h0001;
              else
                acc_l_ff <= acc_l_ff + 16'h0001;
            end
            cnt_ff <= cnt_ff + 16'h0001;
            if (cnt_ff == dstk_pkg::CYC_LEN[cyc_code] - 16'h0001)
            begin
              cnt_ff <= 16'h0000;
              seq_ff <= seq_ff + 4'h1;
              if (seq_last)
                state_ff <= dstk_pkg::ST_DONE;
              else
                state_ff <= (auto_mode & gap_en_ff) ? dstk_pkg::ST_GAP
                                                    : dstk_pkg::ST_SETTLE;
            end
          end
        dstk_pkg::ST_DONE:
          state_ff <= dstk_pkg::ST_IDLE;
        default:
          state_ff <= dstk_pkg::ST_IDLE;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o_ff <= 1'b0;
      wake_o_ff <= 1'b0;
      afe_ff <= '0;
    end
    else
    begin
      irq_o_ff <= irq_flag_ff & cfg_a_ff[dstk_pkg::A_IEN];
      if (done_evt & auto_hit)
        wake_o_ff <= 1'b1;
      else if (~auto_mode | ~conv_en)
        wake_o_ff <= 1'b0;
      afe_ff.analog_on <= conv_en;
      afe_ff.comparator_low_power <= cfg_a_ff[dstk_pkg::A_LPM];
      afe_ff.integ_zero <= (state_ff != dstk_pkg::ST_COUNT);
      afe_ff.charge_up <= phase_ff;
      afe_ff.transfer <= tick_ff & (state_ff == dstk_pkg::ST_COUNT)
                         & (~prnd_en_ff | lfsr_ff[0]);
      afe_ff.guard_drive <= cfg_a_ff[dstk_pkg::A_SHIELD] & conv_en & phase_ff;
      afe_ff.reference_cap_select <= cap_sel_ff;
      afe_ff.dc_bias <= dc_bias_ff;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;
  assign irq_o = irq_o_ff;
  assign wake_o = wake_o_ff;
  assign afe_o = afe_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_disable_clears: assert property (!conv_en |=> state_ff == dstk_pkg::ST_IDLE)
    else $error("sequencer not idle after disable");
  a_done_sets_flag: assert property (done_evt && cfg_a_ff[dstk_pkg::A_IEN] && !auto_mode
    |=> irq_flag_ff ##1 irq_o)
    else $error("completion did not raise interrupt");
  a_flag_set_wins: assert property (done_evt && cfg_a_ff[dstk_pkg::A_IEN] && auto_hit
    |=> irq_flag_ff)
    else $error("interrupt flag lost");
  a_auto_wake_hit: assert property (done_evt && auto_hit |=> wake_o)
    else $error("wake not raised on threshold hit");
  a_start_while_busy: assert property (busy && wr_d |-> !start_req)
    else $error("start accepted while busy");
  a_settle_length: assert property (state_ff == dstk_pkg::ST_SETTLE && cnt_ff == 16'h0000
    && tick_ff && settle == 2'b00 ##1 (state_ff == dstk_pkg::ST_SETTLE && !tick_ff)[*1]
    |-> cnt_ff == 16'h0001)
    else $error("settle counter not advancing");
  a_seq_exact_end: assert property (state_ff == dstk_pkg::ST_COUNT && tick_ff
    && cnt_ff == dstk_pkg::CYC_LEN[cyc_code] - 16'h0001 |=> state_ff != dstk_pkg::ST_COUNT
    || cnt_ff == 16'h0000)
    else $error("sequence overran its length");
  a_count_bounded: assert property (state_ff == dstk_pkg::ST_COUNT
    |-> cnt_ff < dstk_pkg::CYC_LEN[cyc_code])
    else $error("cycle counter beyond length");
  a_busy_readback: assert property (ack_o && $past(idx) == dstk_pkg::IDX_CFG_D && !$past(we_i)
    |-> dat_o[dstk_pkg::D_START] == $past(busy))
    else $error("busy readback mismatch");
  a_cap_forward: assert property ($changed(cap_sel_ff) |=> afe_o.reference_cap_select
    == $past(cap_sel_ff))
    else $error("reference cap not forwarded");
  c_normal_done: cover property (done_evt && !auto_mode && seq_ff == 4'h4);
  c_auto_wake: cover property (done_evt && auto_hit);
  c_noise_seen: cover property (state_ff == dstk_pkg::ST_COUNT && noisy);
endmodule : dstk_sequencer
`default_nettype wire

// >>> dv/dstk_afe_model.sv
// behavioural analog front end: integration node with two comparator thresholds
// assumes afe_i is driven by the sequencer on clk_i
`default_nettype none
module dstk_afe_model (
  input wire logic clk_i,                    // system clock
  input wire dstk_pkg::dstk_afe_type afe_i,  // controls from the sequencer
  output logic comp_o                        // 1 above upper threshold, 0 below lower
);
  timeunit 1ns;
  timeprecision 1ns;
  int level = 32;
  // charge 3, discharge 2 per transfer, so the two phase counts really differ
  always @(posedge clk_i)
  begin
    if (!afe_i.analog_on || afe_i.integ_zero)
      level <= 32;
    else if (afe_i.transfer)
      level <= afe_i.charge_up ? level + 3 : level - 2;
  end
  // hysteresis band; a powered-down comparator reads low
  always @(posedge clk_i)
  begin
    if (!afe_i.analog_on)
      comp_o <= 1'b0;
    else if (level >= 48)
      comp_o <= 1'b1;
    else if (level <= 16)
      comp_o <= 1'b0;
  end
endmodule : dstk_afe_model
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the touch key sequencer over classic wishbone
// assumes the front end model in dstk_afe_model; slow oscillator unused here
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, comp;
  logic [17:0] adr = 18'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack_o, irq_o, wake_o;
  logic [7:0] q, lo;
  logic [15:0] hc, hs;
  dstk_pkg::dstk_afe_type afe;
  int n_fail = 0, checks = 0, cycles = 0;
  dstk_sequencer i_dstk_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .slow_osc_i(1'b0), .comp_i(comp), .afe_o(afe), .irq_o(irq_o), .wake_o(wake_o));
  dstk_afe_model i_dstk_afe_model (.clk_i(clk_i), .afe_i(afe), .comp_o(comp));
  // 50 MHz clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  // hang guard: longest run is a few thousand conversion ticks
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, called just after a rising edge; the request stands until
  // the edge that samples ack high, data is taken there, then one idle cycle
  task wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task rd16(input logic [15:0] idx);
    wb(1'b0, idx, 8'h00);
    lo = q;
    wb(1'b0, idx + 16'h1, 8'h00);
    hc = {q, lo};
  endtask : rd16
  task wait_irq;
    do @(posedge clk_i); while (irq_o !== 1'b1);
  endtask : wait_irq
  // run one normal conversion and check the phase totals add up to its length
  task convert(input logic [7:0] cmd, input logic [15:0] total);
    logic [15:0] h;
    wb(1'b1, dstk_pkg::IDX_CFG_D, cmd);
    wb(1'b0, dstk_pkg::IDX_CFG_D, 8'h00);
    chk(q[0], 1'b1);
    chk({afe.guard_drive, afe.charge_up}, 2'h3);
    wait_irq;
    rd16(dstk_pkg::IDX_HPC_L);
    h = hc;
    rd16(dstk_pkg::IDX_LPC_L);
    chk(h + hc, total);
    wb(1'b0, dstk_pkg::IDX_CFG_D, 8'h00);
    chk(q[1:0], 2'h2);
    wb(1'b1, dstk_pkg::IDX_CFG_D, {cmd[7:5], 5'h00});
    @(posedge clk_i);
    chk(irq_o, 1'b0);
  endtask : convert
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // every register reads its reset value; an unmapped slot reads zero
    for (int i = 0; i < 21; i++)
    begin
      wb(1'b0, dstk_pkg::IDX_CFG_A + 16'(i), 8'hff);
      chk(q, 8'h00);
    end
    wb(1'b1, dstk_pkg::IDX_HPC_L, 8'h5a);
    wb(1'b0, dstk_pkg::IDX_HPC_L, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, dstk_pkg::IDX_BASE_H, 8'ha5);
    wb(1'b0, dstk_pkg::IDX_BASE_H, 8'h00);
    chk(q, 8'ha5);
    // converter on, fast clock, irq enabled, shield and low power on
    wb(1'b1, dstk_pkg::IDX_CFG_A, 8'h8e);
    @(posedge clk_i);
    chk({afe.analog_on, afe.comparator_low_power}, 2'h3);
    convert(8'ha7, 16'h0400);
    chk(afe.reference_cap_select, 3'h5);
    wb(1'b1, dstk_pkg::IDX_CFG_B, 8'h40);
    convert(8'h0f, 16'h1000);
    // divide by 4, noise filter at 8: long runs in either phase drop out of the totals
    wb(1'b1, dstk_pkg::IDX_CFG_A, 8'h9e);
    wb(1'b1, dstk_pkg::IDX_CFG_B, 8'h01);
    wb(1'b1, dstk_pkg::IDX_CFG_D, 8'h01);
    wait_irq;
    rd16(dstk_pkg::IDX_HPC_L);
    hs = hc;
    rd16(dstk_pkg::IDX_LPC_L);
    chk({15'h0000, (hs + hc < 16'h0400)}, 16'h0001);
    wb(1'b0, dstk_pkg::IDX_CFG_D, 8'h00);
    chk(q[2:0], 3'h6);
    wb(1'b1, dstk_pkg::IDX_CFG_D, 8'h00);
    // auto mode, absolute threshold of zero: any low count wakes; seeded baseline
    wb(1'b1, dstk_pkg::IDX_CFG_B, 8'h00);
    wb(1'b1, dstk_pkg::IDX_CFG_C, 8'h04);
    wb(1'b1, dstk_pkg::IDX_CFG_A, 8'h85);
    wait_irq;
    chk(wake_o, 1'b1);
    rd16(dstk_pkg::IDX_LPC_L);
    hs = hc;
    rd16(dstk_pkg::IDX_BASE_L);
    chk(hc, hs);
    wb(1'b1, dstk_pkg::IDX_CFG_A, 8'h00);
    @(posedge clk_i);
    @(posedge clk_i);
    chk({wake_o, afe.analog_on, afe.guard_drive}, 3'h0);
    wb(1'b0, dstk_pkg::IDX_CFG_D, 8'h00);
    chk(q[0], 1'b0);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
